// ---- rtl/vic_pkg.sv ----
/*
 * Constants for the vectored interrupt controller: source map, vector table
 * addresses, reset values and sequencer states.
 * Assumes one 100 MHz clock and an asynchronous active-low reset.
 */
package vic_pkg;
    // ---------------------------------------------------------------
    // Sizes
    // ---------------------------------------------------------------
    localparam int unsigned NUM_SRC   = 20;
    localparam int unsigned NUM_ENT   = 8;
    localparam int unsigned ENT_W     = 3;

    // ---------------------------------------------------------------
    // Source indices
    // ---------------------------------------------------------------
    localparam int unsigned SRC_TOVF1  = 0;
    localparam int unsigned SRC_TOVF2  = 1;
    localparam int unsigned SRC_CONV   = 2;
    localparam int unsigned SRC_CAPHLD = 3;
    localparam int unsigned SRC_CAPF6  = 4;
    localparam int unsigned SRC_TOUT0  = 5;   // 5..11 timed output events
    localparam int unsigned SRC_CAPZ   = 12;
    localparam int unsigned SRC_SWT0   = 13;  // 13..16 software timers
    localparam int unsigned SRC_SER0   = 17;  // 17..18 serial port
    localparam int unsigned SRC_EXT    = 19;

    // Entry (= priority level) of each source, index 0 in the low bits
    localparam logic [NUM_SRC*ENT_W-1:0] SRC_ENTRY = {
        3'h7, 3'h6, 3'h6, 3'h5, 3'h5, 3'h5, 3'h5, 3'h4,
        3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3,
        3'h2, 3'h2, 3'h1, 3'h0, 3'h0};

    // ---------------------------------------------------------------
    // Vector table
    // ---------------------------------------------------------------
    localparam logic [15:0] VEC_BASE   = 16'h2000;
    localparam logic [15:0] VEC_TRAP   = 16'h2010;
    localparam logic [15:0] VEC_NMI    = 16'h0000;
    localparam logic [15:0] VEC_LAST   = 16'h2011;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [7:0]  PEND_RST   = 8'h00;
    localparam logic [7:0]  MASK_RST   = 8'h00;
    localparam logic        GIE_RST    = 1'b0;

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        VIC_IDLE = 3'b000,
        VIC_PUSH = 3'b001,
        VIC_RDLO = 3'b010,
        VIC_RDHI = 3'b011,
        VIC_LOAD = 3'b100,
        VIC_POP  = 3'b101
    } vic_state_e;

    typedef enum logic [1:0] {
        VIC_K_HW   = 2'b00,
        VIC_K_TRAP = 2'b01,
        VIC_K_NMI  = 2'b10
    } vic_kind_e;
endpackage : vic_pkg

// ---- rtl/vic_top.sv ----
/*
 * Vectored interrupt controller: edge capture of twenty sources into eight
 * pending bits, masking, fixed priority, push, vector fetch and reload,
 * software trap, non-maskable entry and return.
 * Assumes the core raises cpu_boundary only between instructions and holds
 * trap_req / subroutine_exit_op until the sequencer answers with pc_load.
 */
`timescale 1ns/1ps

// Contract
// - Twenty sources share eight vector entries
// - Rising edge sets pending, level does not
// - Masked pending requests stay, never taken
// - Take pushes PC then loads vector
// - Vectors fetched 2000H-2011H, low byte even
// - Trap uses 2010H, outside arbitration
// - External input 200EH, priority seven highest
// - Serial 200CH prio6, timers 200AH prio5
// - Capture data 2004H, conversion 2002H
// - Timer overflow 2000H, lowest priority
// - Priority only orders simultaneous requests
// - Any handler may be interrupted again
// - Software reads/writes pending and mask
// - Return pops saved PC and resumes
// - NMI edge clears watchdog, jumps 0000H
// - Capture data on hold or sixth
// - Either timer wrap raises overflow request
module vic_top (
    input  wire logic                          clk,
    input  wire logic                          rstn,
    input  wire logic [vic_pkg::NUM_SRC-1:0]   src_evt,
    input  wire logic                          cap_sel_fifo6,
    input  wire logic [1:0]                    tovf_en,
    input  wire logic                          nmi,
    input  wire logic                          cpu_boundary,
    input  wire logic [15:0]                   pc_cur,
    input  wire logic                          trap_req,
    input  wire logic                          subroutine_exit_op,
    input  wire logic                          gie_set,
    input  wire logic                          gie_clr,
    input  wire logic                          pend_wr,
    input  wire logic [7:0]                    pend_wdata,
    input  wire logic                          mask_wr,
    input  wire logic [7:0]                    mask_wdata,
    output logic      [7:0]                    pend,
    output logic      [7:0]                    mask,
    output logic                               gie,
    output logic                               push_req,
    output logic      [15:0]                   push_data,
    input  wire logic                          push_ack,
    output logic                               pop_req,
    input  wire logic [15:0]                   pop_data,
    input  wire logic                          pop_ack,
    output logic                               vec_rd_req,
    output logic      [15:0]                   vec_rd_addr,
    input  wire logic [7:0]                    vec_rd_data,
    input  wire logic                          vec_rd_ack,
    output logic                               pc_load,
    output logic      [15:0]                   pc_load_data,
    output logic                               wdt_clear,
    output logic                               busy
);
    import vic_pkg::*;

    typedef struct packed {
        vic_state_e          st;
        vic_kind_e           kind;
        logic [ENT_W-1:0]    ent;
        logic [7:0]          pend;
        logic [7:0]          mask;
        logic                gie;
        logic [NUM_SRC-1:0]  prev;
        logic                nmi_prev;
        logic                nmi_pend;
        logic                wdt_clear;
        logic [15:0]         push_data;
        logic [15:0]         addr;
        logic [15:0]         vec;
    } vic_s;

    vic_s                    s_reg;
    vic_s                    s_next;
    logic [NUM_SRC-1:0]      qual;
    logic [NUM_SRC-1:0]      rise;
    logic [7:0]              ent_set;
    logic [7:0]              avail;
    logic [ENT_W-1:0]        win;
    logic                    hw_req;
    logic [7:0]              take_mask;

    // ---------------------------------------------------------------
    // Source qualification and edge capture
    // ---------------------------------------------------------------
    always_comb begin
        qual = src_evt;
        qual[SRC_CAPHLD] = src_evt[SRC_CAPHLD] & ~cap_sel_fifo6;
        qual[SRC_CAPF6]  = src_evt[SRC_CAPF6] & cap_sel_fifo6;
        qual[SRC_TOVF1]  = src_evt[SRC_TOVF1] & tovf_en[0];
        qual[SRC_TOVF2]  = src_evt[SRC_TOVF2] & tovf_en[1];
    end

    // A select change on a high source looks like an edge; software owns it
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SRC; gi = gi + 1) begin : g_src
            assign rise[gi] = qual[gi] & ~s_reg.prev[gi];
        end
    endgenerate

    always_comb begin
        ent_set = 8'h00;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (rise[i]) begin
                ent_set[SRC_ENTRY[i*ENT_W +: ENT_W]] = 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Arbitration
    // ---------------------------------------------------------------
    always_comb begin
        avail  = s_reg.pend & s_reg.mask & {8{s_reg.gie}};
        hw_req = |avail;
        win    = 3'h0;
        // Highest entry wins; no in-service state blocks anyone
        for (int i = 0; i < NUM_ENT; i++) begin
            if (avail[i]) begin
                win = i[ENT_W-1:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        take_mask = 8'h00;
        s_next.prev = qual;
        s_next.nmi_prev = nmi;
        s_next.wdt_clear = 1'b0;
        if (nmi & ~s_reg.nmi_prev) begin
            s_next.nmi_pend  = 1'b1;
            s_next.wdt_clear = 1'b1;
        end
        if (gie_clr) begin
            s_next.gie = 1'b0;
        end else if (gie_set) begin
            s_next.gie = 1'b1;
        end
        if (mask_wr) begin
            s_next.mask = mask_wdata;
        end
        case (s_reg.st)
            VIC_IDLE: begin
                if (cpu_boundary & (s_reg.nmi_pend | trap_req | hw_req)) begin
                    s_next.st        = VIC_PUSH;
                    s_next.push_data = pc_cur;
                    if (s_reg.nmi_pend) begin
                        s_next.kind     = VIC_K_NMI;
                        s_next.nmi_pend = 1'b0;
                        s_next.vec      = VEC_NMI;
                    end else if (trap_req) begin
                        s_next.kind = VIC_K_TRAP;
                        s_next.addr = VEC_TRAP;
                    end else begin
                        s_next.kind = VIC_K_HW;
                        s_next.ent  = win;
                        // Entry n sits at base + 2n
                        s_next.addr = VEC_BASE + {12'h000, win, 1'b0};
                        take_mask[win] = 1'b1;
                    end
                end else if (subroutine_exit_op) begin
                    s_next.st = VIC_POP;
                end
            end
            VIC_PUSH: begin
                if (push_ack) begin
                    s_next.st = (s_reg.kind == VIC_K_NMI) ? VIC_LOAD : VIC_RDLO;
                end
            end
            VIC_RDLO: begin
                if (vec_rd_ack) begin
                    s_next.vec[7:0] = vec_rd_data;
                    s_next.addr     = s_reg.addr + 16'h0001;
                    s_next.st       = VIC_RDHI;
                end
            end
            VIC_RDHI: begin
                if (vec_rd_ack) begin
                    s_next.vec[15:8] = vec_rd_data;
                    s_next.st        = VIC_LOAD;
                end
            end
            VIC_POP: begin
                if (pop_ack) begin
                    s_next.vec = pop_data;
                    s_next.st  = VIC_LOAD;
                end
            end
            VIC_LOAD: begin
                s_next.st = VIC_IDLE;
            end
            default: begin
                s_next.st = VIC_IDLE;
            end
        endcase
        // A new edge beats both the take and a software write
        s_next.pend = ((pend_wr ? pend_wdata : s_reg.pend) & ~take_mask) | ent_set;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_reg <= '{st: VIC_IDLE, kind: VIC_K_HW, ent: 3'h0,
                       pend: PEND_RST, mask: MASK_RST, gie: GIE_RST,
                       prev: '0, nmi_prev: 1'b0, nmi_pend: 1'b0,
                       wdt_clear: 1'b0, push_data: 16'h0000,
                       addr: 16'h0000, vec: 16'h0000};
        end else begin
            s_reg <= s_next;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign pend         = s_reg.pend;
    assign mask         = s_reg.mask;
    assign gie          = s_reg.gie;
    assign push_req     = (s_reg.st == VIC_PUSH);
    assign push_data    = s_reg.push_data;
    assign pop_req      = (s_reg.st == VIC_POP);
    assign vec_rd_req   = (s_reg.st == VIC_RDLO) | (s_reg.st == VIC_RDHI);
    assign vec_rd_addr  = s_reg.addr;
    assign pc_load      = (s_reg.st == VIC_LOAD);
    assign pc_load_data = s_reg.vec;
    assign wdt_clear    = s_reg.wdt_clear;
    assign busy         = (s_reg.st != VIC_IDLE);

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    sequence seq_take;
        s_reg.st == VIC_IDLE && cpu_boundary && !s_reg.nmi_pend && !trap_req && hw_req;
    endsequence
    sequence seq_fetch;
        s_reg.st == VIC_RDHI && vec_rd_ack;
    endsequence
    AST_FETCH_LOW: assert property (@(posedge clk) disable iff (!rstn)
        (s_reg.st == VIC_RDLO && vec_rd_ack) |=> s_reg.vec[7:0] == $past(vec_rd_data))
        else $error("low vector byte not captured");

    AST_TAKE_PUSH: assert property (@(posedge clk) disable iff (!rstn)
        seq_take |=> push_req && push_data == $past(pc_cur))
        else $error("take did not push the program counter");

    AST_MASKED_HOLD: assert property (@(posedge clk) disable iff (!rstn)
        (pend[2] && !mask[2] && !pend_wr) |=> pend[2])
        else $error("masked pending bit was lost");

    AST_NO_GIE_NO_TAKE: assert property (@(posedge clk) disable iff (!rstn)
        (s_reg.st == VIC_IDLE && !gie && !trap_req && !s_reg.nmi_pend) |=> !push_req)
        else $error("request taken with global enable off");

    AST_EDGE_SET: assert property (@(posedge clk) disable iff (!rstn)
        (src_evt[SRC_EXT] && !$past(src_evt[SRC_EXT])) |=> pend[7])
        else $error("external edge did not set pending");

    AST_VEC_ADDR: assert property (@(posedge clk) disable iff (!rstn)
        vec_rd_req |-> vec_rd_addr >= VEC_BASE && vec_rd_addr <= VEC_LAST)
        else $error("vector fetch outside the table");

    AST_HIGH_WINS: assert property (@(posedge clk) disable iff (!rstn)
        (seq_take and (avail[7] && avail[0])) |=> vec_rd_addr == 16'h200e)
        else $error("external input lost arbitration");

    AST_TRAP_ADDR: assert property (@(posedge clk) disable iff (!rstn)
        (s_reg.st == VIC_IDLE && cpu_boundary && !s_reg.nmi_pend && trap_req)
        |=> push_req && s_reg.addr == VEC_TRAP)
        else $error("trap vector address wrong");

    AST_FETCH_LOAD: assert property (@(posedge clk) disable iff (!rstn)
        seq_fetch |=> pc_load && pc_load_data[15:8] == $past(vec_rd_data))
        else $error("loaded vector differs from fetched bytes");

    AST_NMI_WDT: assert property (@(posedge clk) disable iff (!rstn)
        (nmi && !$past(nmi)) |=> wdt_clear ##1 !wdt_clear)
        else $error("nmi edge did not pulse watchdog clear");

    AST_POP_LOAD: assert property (@(posedge clk) disable iff (!rstn)
        (pop_req && pop_ack) |=> pc_load && pc_load_data == $past(pop_data))
        else $error("return did not reload popped value");

    AST_TAKE_CLEARS: assert property (@(posedge clk) disable iff (!rstn)
        (seq_take and (avail == 8'h01) && !pend_wr && !ent_set[0]) |=> !pend[0])
        else $error("serviced pending bit not cleared");
endmodule : vic_top

// ---- verif/vic_core_model.sv ----
/*
 * Core-side model for the interrupt controller: stack, vector table reads.
 * Assumes one clock; dly sets answer latency in cycles.
 */
`timescale 1ns/1ps
module vic_core_model (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [3:0]  dly,
    input  wire logic        push_req,
    input  wire logic [15:0] push_data,
    output logic             push_ack,
    input  wire logic        pop_req,
    output logic      [15:0] pop_data,
    output logic             pop_ack,
    input  wire logic        vec_rd_req,
    input  wire logic [15:0] vec_rd_addr,
    output logic      [7:0]  vec_rd_data,
    output logic             vec_rd_ack
);
    logic [15:0] stack[$];
    logic [3:0]  cnt;
    // ---------------------------------------------------------------
    // Handshake answers
    // ---------------------------------------------------------------
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {push_ack, pop_ack, vec_rd_ack} <= 3'h0;
            pop_data    <= 16'h0000;
            vec_rd_data <= 8'h00;
            cnt         <= 4'h0;
        end else begin
            {push_ack, pop_ack, vec_rd_ack} <= 3'h0;
            // Released buses toggle so stale data never looks valid
            vec_rd_data <= ~vec_rd_data;
            pop_data    <= ~pop_data;
            if (push_ack | pop_ack | vec_rd_ack) begin
                cnt <= 4'h0;
            end else if (push_req | pop_req | vec_rd_req) begin
                if (cnt >= dly) begin
                    cnt <= 4'h0;
                    if (push_req) begin
                        stack.push_back(push_data);
                        push_ack <= 1'b1;
                    end else if (pop_req) begin
                        if (stack.size() > 0) pop_data <= stack.pop_back();
                        pop_ack <= 1'b1;
                    end else begin
                        // Table byte = address low byte plus 40h
                        vec_rd_data <= vec_rd_addr[7:0] + 8'h40;
                        vec_rd_ack  <= 1'b1;
                    end
                end else begin
                    cnt <= cnt + 4'h1;
                end
            end
        end
    end
endmodule : vic_core_model

// ---- verif/vic_top_tb_top.sv ----
/*
 * Self-checking bench for vic_top with the core model as far side.
 * Assumes 100 MHz clock and vic_pkg constants.
 */
`timescale 1ns/1ps
module vic_top_tb_top;
    import vic_pkg::*;
    logic        clk, rstn, cap_sel_fifo6, nmi, cpu_boundary, trap_req;
    logic        subroutine_exit_op, gie_set, gie_clr, pend_wr, mask_wr;
    logic        gie, push_req, push_ack, pop_req, pop_ack, vec_rd_req;
    logic        vec_rd_ack, pc_load, wdt_clear, busy;
    logic [19:0] src_evt;
    logic [1:0]  tovf_en;
    logic [3:0]  dly;
    logic [7:0]  pend_wdata, mask_wdata, pend, mask, vec_rd_data;
    logic [15:0] pc_cur, push_data, pop_data, vec_rd_addr, pc_load_data;
    int          err_count, checks_done, cycles;

    vic_top dut (.clk, .rstn, .src_evt, .cap_sel_fifo6, .tovf_en, .nmi, .cpu_boundary,
        .pc_cur, .trap_req, .subroutine_exit_op, .gie_set, .gie_clr, .pend_wr,
        .pend_wdata, .mask_wr, .mask_wdata, .pend, .mask, .gie, .push_req, .push_data,
        .push_ack, .pop_req, .pop_data, .pop_ack, .vec_rd_req, .vec_rd_addr,
        .vec_rd_data, .vec_rd_ack, .pc_load, .pc_load_data, .wdt_clear, .busy);
    vic_core_model core (.clk, .rstn, .dly, .push_req, .push_data, .push_ack, .pop_req,
        .pop_data, .pop_ack, .vec_rd_req, .vec_rd_addr, .vec_rd_data, .vec_rd_ack);

    always #5 clk = ~clk;
    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : complete_run

    always @(posedge clk) begin
        cycles++;
        if (cycles >= 20000) begin
            err_count++;
            complete_run();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    function automatic logic [15:0] vec(input int e);
        return 16'h4140 + 16'(e) * 16'h0202;
    endfunction : vec

    function automatic int ent_of(input int s);
        return s < 2 ? 0 : s < 3 ? 1 : s < 5 ? 2 : s < 12 ? 3 : s < 13 ? 4 :
               s < 17 ? 5 : s < 19 ? 6 : 7;
    endfunction : ent_of

    task automatic swr(input logic [7:0] m, input logic [7:0] p);
        @(posedge clk) {mask_wdata, pend_wdata, mask_wr, pend_wr} <= {m, p, 2'b11};
        @(posedge clk) {mask_wr, pend_wr} <= 2'b00;
    endtask : swr

    task automatic pulse_gie(input logic set);
        @(posedge clk) {gie_set, gie_clr} <= {set, ~set};
        @(posedge clk) {gie_set, gie_clr} <= 2'b00;
    endtask : pulse_gie

    task automatic serve(input string what, input logic [15:0] exp_push,
                         input logic [15:0] exp_pc, input logic exp_pushed);
        int   n;
        logic pushed;
        pushed = 1'b0;
        for (n = 0; n < 300; n++) begin
            @(negedge clk);
            if (push_req === 1'b1 && !pushed) begin
                pushed = 1'b1;
                chk({what, " push"}, exp_push, push_data);
            end
            if (pc_load === 1'b1) break;
        end
        chk({what, " load"}, 16'h1, {15'h0, pc_load});
        chk({what, " pushed"}, {15'h0, exp_pushed}, {15'h0, pushed});
        chk(what, exp_pc, pc_load_data);
    endtask : serve
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_sources;
        for (int s = 0; s < 20; s++) begin
            @(posedge clk) {cap_sel_fifo6, src_evt} <= {s == 4, 20'h1 << s};
            repeat (2) @(posedge clk);
            @(negedge clk) chk("pend src", 16'(8'h1 << ent_of(s)), {8'h0, pend});
            swr(8'h00, 8'h00);
            repeat (3) @(posedge clk);
            @(negedge clk) chk("pend level", 16'h0, {8'h0, pend});
            @(posedge clk) src_evt <= 20'h0;
        end
        @(posedge clk) {tovf_en, cap_sel_fifo6, src_evt} <= {2'b00, 1'b1, 20'h9};
        repeat (3) @(posedge clk);
        @(negedge clk) chk("gated src", 16'h0, {8'h0, pend});
        @(posedge clk) {tovf_en, src_evt} <= {2'b11, 20'h0};
        $display("test sources done");
    endtask : t_sources

    task automatic t_mask;
        pulse_gie(1'b1);
        swr(8'h00, 8'h10);
        repeat (20) @(posedge clk);
        @(negedge clk) chk("masked", 16'h10, {7'h0, busy, pend});
        pulse_gie(1'b0);
        swr(8'h10, 8'h10);
        repeat (20) @(posedge clk);
        @(negedge clk) chk("no gie", 16'h1010, {mask, pend});
        chk("busy", 16'h0, {15'h0, busy});
        swr(8'h00, 8'h00);
        $display("test mask done");
    endtask : t_mask

    task automatic t_prio;
        @(posedge clk) {dly, pc_cur} <= {4'h3, 16'h1000};
        pulse_gie(1'b1);
        swr(8'hff, 8'hff);
        for (int e = 7; e >= 0; e--) begin
            serve("prio", 16'h1000, vec(e), 1'b1);
            chk("pend left", 16'((8'h1 << e) - 1), {8'h0, pend});
        end
        $display("test priority done");
    endtask : t_prio

    task automatic t_nest;
        @(posedge clk) {dly, pc_cur} <= {4'h0, 16'h1111};
        swr(8'h01, 8'h01);
        serve("low", 16'h1111, vec(0), 1'b1);
        @(posedge clk) pc_cur <= 16'h2222;
        swr(8'h81, 8'h80);
        serve("nested", 16'h2222, vec(7), 1'b1);
        swr(8'h00, 8'h00);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk) subroutine_exit_op <= 1'b1;
            serve("return", 16'h0, i == 0 ? 16'h2222 : 16'h1111, 1'b0);
            @(posedge clk) subroutine_exit_op <= 1'b0;
        end
        $display("test nesting done");
    endtask : t_nest

    task automatic t_trap;
        pulse_gie(1'b0);
        swr(8'hff, 8'hff);
        @(posedge clk) {dly, pc_cur, trap_req} <= {4'h2, 16'h3333, 1'b1};
        serve("trap", 16'h3333, vec(8), 1'b1);
        @(posedge clk) trap_req <= 1'b0;
        @(negedge clk) chk("trap pend", 16'hff, {8'h0, pend});
        swr(8'h00, 8'h00);
        $display("test trap done");
    endtask : t_trap

    task automatic t_nmi;
        @(posedge clk) {dly, pc_cur, nmi} <= {4'h3, 16'h4444, 1'b1};
        @(posedge clk);
        @(negedge clk) chk("wdt pulse", 16'h1, {15'h0, wdt_clear});
        @(negedge clk) chk("wdt end", 16'h0, {15'h0, wdt_clear});
        serve("nmi", 16'h4444, VEC_NMI, 1'b1);
        @(posedge clk) nmi <= 1'b0;
        $display("test nmi done");
    endtask : t_nmi

    task automatic t_reset;
        pulse_gie(1'b1);
        swr(8'h0f, 8'hf0);
        @(negedge clk) chk("before reset", 16'h0ff0, {mask, pend});
        chk("gie before reset", 16'h1, {15'h0, gie});
        @(posedge clk) rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk) chk("mid-run reset", 16'h0, {pend, mask} | {15'h0, gie});
        @(negedge clk) chk("busy after reset", 16'h0, {15'h0, busy});
        $display("test reset done");
    endtask : t_reset
    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        {clk, rstn, cap_sel_fifo6, nmi, trap_req, subroutine_exit_op} = 6'h0;
        {gie_set, gie_clr, pend_wr, mask_wr, pend_wdata, mask_wdata} = 20'h0;
        {src_evt, tovf_en, dly, pc_cur, cpu_boundary} = {20'h0, 2'b11, 4'h0, 16'h0, 1'b1};
        {err_count, checks_done, cycles} = '0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk) chk("reset state", 16'h0, {pend, mask} | {15'h0, gie});
        t_sources();
        t_mask();
        t_prio();
        t_nest();
        t_trap();
        t_nmi();
        t_reset();
        complete_run();
    end
endmodule : vic_top_tb_top
